// ==== hw/isp_pkg.sv ====
// register map, field positions and reset values of the interrupt logic
package isp_pkg;

  // register offsets on the plain register port
  localparam logic [3:0] OFS_IRQ_STATUS   = 4'h0;
  localparam logic [3:0] OFS_IRQ_ENABLE   = 4'h1;
  localparam logic [3:0] OFS_MAIN_CTRL    = 4'h2;
  localparam logic [3:0] OFS_SECOND_CTRL  = 4'h3;
  localparam logic [3:0] OFS_THIRD_CTRL   = 4'h4;
  localparam logic [3:0] OFS_CAN_PRIORITY = 4'h5;
  localparam logic [3:0] OFS_RESET_CAUSE  = 4'h6;
  localparam logic [3:0] OFS_TIMER0_LOW   = 4'h7;
  localparam logic [3:0] OFS_TIMER0_HIGH  = 4'h8;

  // status and enable bit positions
  localparam int SRC_EXT0    = 0;
  localparam int SRC_EXT1    = 1;
  localparam int SRC_EXT2    = 2;
  localparam int SRC_TIMER0  = 3;
  localparam int SRC_PORTCHG = 4;
  localparam int SRC_COUNT   = 5;

  // main control fields
  localparam int MAIN_GLOBAL_EN = 7;
  localparam int MAIN_LOW_EN    = 6;
  localparam int MAIN_T0_16BIT  = 0;

  // second control fields: edge selects and priorities
  localparam int SEC_EDGE0   = 6;
  localparam int SEC_EDGE1   = 5;
  localparam int SEC_EDGE2   = 4;
  localparam int SEC_T0_PRI  = 2;
  localparam int SEC_PCH_PRI = 0;

  // third control fields
  localparam int THIRD_EXT2_PRI = 7;
  localparam int THIRD_EXT1_PRI = 6;

  // reset cause register fields
  localparam int RC_PRI_EN   = 7;
  localparam int RC_INSTR    = 4;
  localparam int RC_WDT      = 3;
  localparam int RC_PWRDN    = 2;

  // reset values
  localparam logic [7:0] RST_MAIN_CTRL   = 8'h00;
  localparam logic [7:0] RST_SECOND_CTRL = 8'h75;
  localparam logic [7:0] RST_THIRD_CTRL  = 8'hc0;
  localparam logic [7:0] RST_CAN_PRI     = 8'hff;
  localparam logic [7:0] RST_RESET_CAUSE = 8'h1c;
  localparam logic [7:0] RC_IMPL_MASK    = 8'h9f;

endpackage

// ==== hw/isp_top.sv ====
// interrupt source flags, priority resolution and register port
`timescale 1ns/1ps

// Overview of operation
// - eight CAN priority bits, reset to one
// - bit 7 selects two-level priority mode
// - reset cause flags bits 4-0, 6-5 zero
// - external pins trigger on selected edge
// - edge sets flag; enable gates request
// - enabled pin flag wakes sleeping core
// - ext1/ext2 priority from third control
// - ext0 is always high priority
// - 8-bit timer overflow FF to 00
// - 16-bit timer overflow FFFF to 0000
// - timer enable and priority bits
// - port B upper nibble change flag
// - port change enable and priority bits
module isp_top (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       nrst,
  // register port
  input  wire logic [3:0] regAddr,
  input  wire logic [7:0] wrData,
  input  wire logic       wrEn,
  input  wire logic       rdEn,
  output logic      [7:0] rdData,
  // pins
  input  wire logic [2:0] extPin,
  input  wire logic [3:0] portBHigh,
  // on-chip sources
  input  wire logic       timer0Tick,
  input  wire logic [7:0] canFlag,
  input  wire logic [4:0] resetCauseSet,
  input  wire logic       cpuSleep,
  // requests to the core
  output logic            irqHigh,
  output logic            irqLow,
  output logic            irqOut,
  output logic            wakeReq
);

  typedef struct packed {
    logic [7:0]                        rdData;
    logic [isp_pkg::SRC_COUNT-1:0]     status;
    logic [isp_pkg::SRC_COUNT-1:0]     enable;
    logic [7:0]                        mainCtl;
    logic [7:0]                        secCtl;
    logic [7:0]                        thirdCtl;
    logic [7:0]                        canPri;
    logic [7:0]                        rcause;
    logic [7:0]                        t0Low;
    logic [7:0]                        t0High;
    logic [2:0]                        pinS1;
    logic [2:0]                        pinS2;
    logic [2:0]                        pinPrev;
    logic [3:0]                        rbS1;
    logic [3:0]                        rbS2;
    logic [3:0]                        rbPrev;
    logic                              irqHigh;
    logic                              irqLow;
    logic                              irqOut;
    logic                              wakeReq;
  } isp_state_t;

  isp_state_t stateReg;
  isp_state_t stateNext;

  // selected edge seen between two synchronised samples
  function automatic logic edgeSeen(input logic prev, input logic cur,
                                    input logic rising);
    edgeSeen = rising ? (!prev && cur) : (prev && !cur);
  endfunction

  // per-source priority with ext0 fixed high
  function automatic logic [isp_pkg::SRC_COUNT-1:0] srcPriority(
      input logic [7:0] sec, input logic [7:0] third);
    srcPriority = '0;
    srcPriority[isp_pkg::SRC_EXT0]    = 1'b1;
    srcPriority[isp_pkg::SRC_EXT1]    = third[isp_pkg::THIRD_EXT1_PRI];
    srcPriority[isp_pkg::SRC_EXT2]    = third[isp_pkg::THIRD_EXT2_PRI];
    srcPriority[isp_pkg::SRC_TIMER0]  = sec[isp_pkg::SEC_T0_PRI];
    srcPriority[isp_pkg::SRC_PORTCHG] = sec[isp_pkg::SEC_PCH_PRI];
  endfunction

  // next state
  always_comb begin
    logic [isp_pkg::SRC_COUNT-1:0] events;
    logic [isp_pkg::SRC_COUNT-1:0] active;
    logic [isp_pkg::SRC_COUNT-1:0] prio;
    logic [15:0]                   t0Count;
    logic [2:0]                    edgeSel;
    logic                          hiAny;
    logic                          loAny;
    logic                          global_irq_enable;
    events  = '0;
    active  = '0;
    prio    = '0;
    t0Count = 16'h0000;
    edgeSel = 3'h0;
    hiAny   = 1'b0;
    loAny   = 1'b0;
    global_irq_enable     = 1'b0;
    stateNext = stateReg;
    stateNext.rdData = 8'h00;

    // two-flop synchronisers, then a third stage for edge detection
    stateNext.pinS1   = extPin;
    stateNext.pinS2   = stateReg.pinS1;
    stateNext.pinPrev = stateReg.pinS2;
    stateNext.rbS1    = portBHigh;
    stateNext.rbS2    = stateReg.rbS1;
    stateNext.rbPrev  = stateReg.rbS2;

    // external pin edges
    edgeSel = {stateReg.secCtl[isp_pkg::SEC_EDGE2],
               stateReg.secCtl[isp_pkg::SEC_EDGE1],
               stateReg.secCtl[isp_pkg::SEC_EDGE0]};
    for (int i = 0; i < 3; i++) begin
      events[isp_pkg::SRC_EXT0 + i] = edgeSeen(stateReg.pinPrev[i],
          stateReg.pinS2[i], edgeSel[i]);
    end

    // any change on the upper port nibble
    events[isp_pkg::SRC_PORTCHG] =
        |(stateReg.rbS2 ^ stateReg.rbPrev);

    // timer counting and overflow
    t0Count = {stateReg.t0High, stateReg.t0Low};
    if (timer0Tick) begin
      if (stateReg.mainCtl[isp_pkg::MAIN_T0_16BIT]) begin
        events[isp_pkg::SRC_TIMER0] = (t0Count == 16'hffff);
        t0Count = t0Count + 16'h0001;
        stateNext.t0High = t0Count[15:8];
        stateNext.t0Low  = t0Count[7:0];
      end else begin
        events[isp_pkg::SRC_TIMER0] = (stateReg.t0Low == 8'hff);
        stateNext.t0Low = stateReg.t0Low + 8'h01;
      end
    end

    // register writes
    if (wrEn) begin
      unique case (regAddr)
        isp_pkg::OFS_IRQ_STATUS:
          stateNext.status = stateReg.status &
              ~wrData[isp_pkg::SRC_COUNT-1:0];
        isp_pkg::OFS_IRQ_ENABLE:
          stateNext.enable = wrData[isp_pkg::SRC_COUNT-1:0];
        isp_pkg::OFS_MAIN_CTRL:
          stateNext.mainCtl = wrData;
        isp_pkg::OFS_SECOND_CTRL:
          stateNext.secCtl = wrData;
        isp_pkg::OFS_THIRD_CTRL:
          stateNext.thirdCtl = wrData;
        isp_pkg::OFS_CAN_PRIORITY:
          stateNext.canPri = wrData;
        isp_pkg::OFS_RESET_CAUSE: begin
          // watchdog and power-down flags are read only
          stateNext.rcause = wrData & isp_pkg::RC_IMPL_MASK;
          stateNext.rcause[isp_pkg::RC_WDT] =
              stateReg.rcause[isp_pkg::RC_WDT];
          stateNext.rcause[isp_pkg::RC_PWRDN] =
              stateReg.rcause[isp_pkg::RC_PWRDN];
        end
        isp_pkg::OFS_TIMER0_LOW:
          stateNext.t0Low = wrData;
        isp_pkg::OFS_TIMER0_HIGH:
          stateNext.t0High = wrData;
        default: ;
      endcase
    end

    // hardware sets win over software clears
    stateNext.status = stateNext.status | events;
    stateNext.rcause[4:0] = stateNext.rcause[4:0] | resetCauseSet;

    // register reads, data in the following cycle only
    if (rdEn) begin
      unique case (regAddr)
        isp_pkg::OFS_IRQ_STATUS:
          stateNext.rdData = {3'h0, stateReg.status};
        isp_pkg::OFS_IRQ_ENABLE:
          stateNext.rdData = {3'h0, stateReg.enable};
        isp_pkg::OFS_MAIN_CTRL:    stateNext.rdData = stateReg.mainCtl;
        isp_pkg::OFS_SECOND_CTRL:  stateNext.rdData = stateReg.secCtl;
        isp_pkg::OFS_THIRD_CTRL:   stateNext.rdData = stateReg.thirdCtl;
        isp_pkg::OFS_CAN_PRIORITY: stateNext.rdData = stateReg.canPri;
        isp_pkg::OFS_RESET_CAUSE:  stateNext.rdData = stateReg.rcause;
        isp_pkg::OFS_TIMER0_LOW:   stateNext.rdData = stateReg.t0Low;
        isp_pkg::OFS_TIMER0_HIGH:  stateNext.rdData = stateReg.t0High;
        default:                   stateNext.rdData = 8'h00;
      endcase
    end

    // priority resolution of enabled, flagged sources
    active = stateReg.status & stateReg.enable;
    prio   = srcPriority(stateReg.secCtl, stateReg.thirdCtl);
    hiAny  = |(active & prio) | |(canFlag & stateReg.canPri);
    loAny  = |(active & ~prio) | |(canFlag & ~stateReg.canPri);
    global_irq_enable    = stateReg.mainCtl[isp_pkg::MAIN_GLOBAL_EN];
    if (stateReg.rcause[isp_pkg::RC_PRI_EN]) begin
      stateNext.irqHigh = global_irq_enable && hiAny;
      stateNext.irqLow  = global_irq_enable && loAny &&
          stateReg.mainCtl[isp_pkg::MAIN_LOW_EN];
    end else begin
      stateNext.irqHigh = global_irq_enable && (hiAny || loAny);
      stateNext.irqLow  = 1'b0;
    end
    stateNext.irqOut  = |active;

    // pin flags wake the core regardless of the global enable
    stateNext.wakeReq = cpuSleep &&
        |(stateReg.status[2:0] & stateReg.enable[2:0]);
  end

  // state register with synchronous reset
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      stateReg          <= '0;
      stateReg.mainCtl  <= isp_pkg::RST_MAIN_CTRL;
      stateReg.secCtl   <= isp_pkg::RST_SECOND_CTRL;
      stateReg.thirdCtl <= isp_pkg::RST_THIRD_CTRL;
      stateReg.canPri   <= isp_pkg::RST_CAN_PRI;
      stateReg.rcause   <= isp_pkg::RST_RESET_CAUSE;
      // samplers keep following the pins through reset, so a pin that
      // idles high shows no false edge once reset lifts; this needs
      // reset held for three clocks
      stateReg.pinS1    <= stateNext.pinS1;
      stateReg.pinS2    <= stateNext.pinS2;
      stateReg.pinPrev  <= stateNext.pinPrev;
      stateReg.rbS1     <= stateNext.rbS1;
      stateReg.rbS2     <= stateNext.rbS2;
      stateReg.rbPrev   <= stateNext.rbPrev;
    end else begin
      stateReg <= stateNext;
    end
  end

  // outputs straight from the state flops
  assign rdData  = stateReg.rdData;
  assign irqHigh = stateReg.irqHigh;
  assign irqLow  = stateReg.irqLow;
  assign irqOut  = stateReg.irqOut;
  assign wakeReq = stateReg.wakeReq;

  // checks on the sources and request logic
  a_can_pri_reset: assert property (@(posedge ref_clk)
    !nrst |=> (stateReg.canPri == 8'hff && !stateReg.rcause[7]))
    else $error("priority reset values wrong");

  a_rcause_unused_zero: assert property (@(posedge ref_clk)
    disable iff (!nrst) rdEn && regAddr == isp_pkg::OFS_RESET_CAUSE
    |=> rdData[6:5] == 2'b00)
    else $error("reset cause bits 6-5 not zero");

  a_rise_sets_flag: assert property (@(posedge ref_clk)
    disable iff (!nrst)
    $rose(stateReg.pinS2[1]) && stateReg.secCtl[isp_pkg::SEC_EDGE1]
    |=> stateReg.status[isp_pkg::SRC_EXT1])
    else $error("rising edge did not set ext1 flag");

  a_fall_sets_flag: assert property (@(posedge ref_clk)
    disable iff (!nrst)
    $fell(stateReg.pinS2[0]) && !stateReg.secCtl[isp_pkg::SEC_EDGE0]
    |=> stateReg.status[isp_pkg::SRC_EXT0])
    else $error("falling edge did not set ext0 flag");

  a_flag_sticky: assert property (@(posedge ref_clk)
    disable iff (!nrst)
    stateReg.status[isp_pkg::SRC_EXT2] &&
    !(wrEn && regAddr == isp_pkg::OFS_IRQ_STATUS && wrData[2])
    |=> stateReg.status[isp_pkg::SRC_EXT2])
    else $error("flag dropped without a clear");

  a_wake_on_pin: assert property (@(posedge ref_clk)
    disable iff (!nrst)
    cpuSleep && stateReg.status[0] && stateReg.enable[0] |=> wakeReq)
    else $error("enabled pin flag did not wake core");

  a_ext0_high_pri: assert property (@(posedge ref_clk)
    disable iff (!nrst)
    stateReg.rcause[7] && stateReg.mainCtl[7] &&
    stateReg.status[0] && stateReg.enable[0] |=> irqHigh)
    else $error("ext0 not raised as high priority");

  a_timer8_overflow: assert property (@(posedge ref_clk)
    disable iff (!nrst)
    timer0Tick && !stateReg.mainCtl[isp_pkg::MAIN_T0_16BIT] &&
    stateReg.t0Low == 8'hff && !wrEn
    |=> stateReg.status[isp_pkg::SRC_TIMER0] && stateReg.t0Low == 8'h00)
    else $error("8-bit overflow missed");

  a_timer16_overflow: assert property (@(posedge ref_clk)
    disable iff (!nrst)
    timer0Tick && stateReg.mainCtl[isp_pkg::MAIN_T0_16BIT] &&
    {stateReg.t0High, stateReg.t0Low} == 16'hffff && !wrEn
    |=> stateReg.status[isp_pkg::SRC_TIMER0] && stateReg.t0High == 8'h00)
    else $error("16-bit overflow missed");

  a_port_change_flag: assert property (@(posedge ref_clk)
    disable iff (!nrst)
    stateReg.rbS2 != stateReg.rbPrev
    |=> stateReg.status[isp_pkg::SRC_PORTCHG])
    else $error("port change not flagged");

  a_single_level: assert property (@(posedge ref_clk)
    disable iff (!nrst)
    !stateReg.rcause[7] |=> !irqLow)
    else $error("low request in single-level mode");

  a_disabled_quiet: assert property (@(posedge ref_clk)
    disable iff (!nrst)
    stateReg.enable == 5'h00 && canFlag == 8'h00 |=> !irqHigh && !irqLow)
    else $error("request without enabled source");

  a_ext1_low_pri: assert property (@(posedge ref_clk)
    disable iff (!nrst)
    stateReg.rcause[isp_pkg::RC_PRI_EN] && stateReg.mainCtl[7:6] == 2'b11 &&
    stateReg.status[isp_pkg::SRC_EXT1] && stateReg.enable[isp_pkg::SRC_EXT1]
    && !stateReg.thirdCtl[isp_pkg::THIRD_EXT1_PRI] |=> irqLow)
    else $error("ext1 low priority not raised");

  a_timer_low_pri: assert property (@(posedge ref_clk)
    disable iff (!nrst)
    stateReg.rcause[isp_pkg::RC_PRI_EN] && stateReg.mainCtl[7:6] == 2'b11 &&
    stateReg.status[isp_pkg::SRC_TIMER0] &&
    stateReg.enable[isp_pkg::SRC_TIMER0] &&
    !stateReg.secCtl[isp_pkg::SEC_T0_PRI] |=> irqLow)
    else $error("timer low priority not raised");

  a_pch_high_pri: assert property (@(posedge ref_clk)
    disable iff (!nrst)
    stateReg.rcause[isp_pkg::RC_PRI_EN] &&
    stateReg.mainCtl[isp_pkg::MAIN_GLOBAL_EN] &&
    stateReg.status[isp_pkg::SRC_PORTCHG] &&
    stateReg.enable[isp_pkg::SRC_PORTCHG] &&
    stateReg.secCtl[isp_pkg::SEC_PCH_PRI] |=> irqHigh)
    else $error("port change high priority not raised");

  a_single_all_high: assert property (@(posedge ref_clk)
    disable iff (!nrst)
    !stateReg.rcause[isp_pkg::RC_PRI_EN] &&
    stateReg.mainCtl[isp_pkg::MAIN_GLOBAL_EN] &&
    (stateReg.status & stateReg.enable) != 5'h00 |=> irqHigh)
    else $error("single-level request not on high line");

  a_can_high_pri: assert property (@(posedge ref_clk)
    disable iff (!nrst)
    stateReg.rcause[isp_pkg::RC_PRI_EN] &&
    stateReg.mainCtl[isp_pkg::MAIN_GLOBAL_EN] &&
    (canFlag & stateReg.canPri) != 8'h00 |=> irqHigh)
    else $error("high priority CAN source not raised");

  a_out_needs_enable: assert property (@(posedge ref_clk)
    disable iff (!nrst)
    (stateReg.status & stateReg.enable) == 5'h00 |=> !irqOut)
    else $error("request output without enabled flag");

endmodule // isp_top

// ==== verification/isp_core_model.sv ====
// core model: sleeps on command and wakes on a wake request
`timescale 1ns/1ps
module isp_core_model (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       nrst,
  // from the interrupt logic
  input  wire logic       wakeReq,
  // bench control and observed state
  input  wire logic       sleepCmd,
  output logic            cpuSleep,
  output logic      [7:0] nWake
);
  // enter sleep on command, leave it and count on a wake request
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      cpuSleep <= 1'b0;
      nWake    <= 8'h00;
    end else if (sleepCmd) begin
      cpuSleep <= 1'b1;
    end else if (cpuSleep && wakeReq) begin
      cpuSleep <= 1'b0;
      nWake    <= nWake + 8'h01;
    end
  end
endmodule // isp_core_model

// ==== verification/test_interrupt_source_priority.sv ====
// self-checking bench for the interrupt source and priority logic
`timescale 1ns/1ps
module test_interrupt_source_priority;
  logic       ref_clk = 1'b0;
  logic       nrst = 1'b0;
  logic [3:0] regAddr = 4'h0;
  logic [7:0] wrData = 8'h00;
  logic       wrEn = 1'b0;
  logic       rdEn = 1'b0;
  logic [7:0] rdData;
  logic [2:0] extPin = 3'h0;
  logic [3:0] portBHigh = 4'h0;
  logic       timer0Tick = 1'b0;
  logic [7:0] canFlag = 8'h00;
  logic [4:0] resetCauseSet = 5'h00;
  logic       cpuSleep, sleepCmd = 1'b0;
  logic       irqHigh, irqLow, irqOut, wakeReq;
  logic [7:0] nWake;
  int         n_fail = 0;
  int         checks = 0;
  logic [3:0] ra [8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h9};
  logic [7:0] rv [8] = '{8'h00, 8'h00, 8'h00, 8'h75, 8'hc0, 8'hff, 8'h1c,
                         8'h00};

  // 25 ns clock
  always #12.5 ref_clk = ~ref_clk;

  isp_top i_isp_top (.ref_clk(ref_clk), .nrst(nrst), .regAddr(regAddr),
    .wrData(wrData), .wrEn(wrEn), .rdEn(rdEn), .rdData(rdData),
    .extPin(extPin), .portBHigh(portBHigh), .timer0Tick(timer0Tick),
    .canFlag(canFlag), .resetCauseSet(resetCauseSet),
    .cpuSleep(cpuSleep), .irqHigh(irqHigh), .irqLow(irqLow),
    .irqOut(irqOut), .wakeReq(wakeReq));

  isp_core_model i_isp_core_model (.ref_clk(ref_clk), .nrst(nrst),
    .wakeReq(wakeReq), .sleepCmd(sleepCmd), .cpuSleep(cpuSleep),
    .nWake(nWake));

  // compare and count
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask

  // print counts and verdict, then stop
  task automatic tally_and_finish;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // one-cycle register write
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    wrEn <= 1'b1;
    regAddr <= a;
    wrData <= d;
    @(posedge ref_clk);
    wrEn <= 1'b0;
  endtask

  // one-cycle read, data checked in the following cycle
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    rdEn <= 1'b1;
    regAddr <= a;
    @(posedge ref_clk);
    rdEn <= 1'b0;
    #1 chk(rdData, exp);
  endtask

  // request outputs as out, high, low
  task automatic irq(input logic [2:0] e);
    #1; // look past the edge, never at it
    chk({5'h00, irqOut, irqHigh, irqLow}, {5'h00, e});
  endtask

  task automatic pin(input logic [2:0] p);
    @(posedge ref_clk);
    extPin <= p;
    idle(6);
  endtask

  task automatic tick(input int n);
    @(posedge ref_clk);
    timer0Tick <= 1'b1;
    idle(n);
    timer0Tick <= 1'b0;
  endtask

  // hang guard
  initial begin
    #100000;
    n_fail++;
    tally_and_finish();
  end

  // main sequence
  initial begin
    idle(4);
    nrst <= 1'b1;
    for (int i = 0; i < 8; i++) rd(ra[i], rv[i]);
    wr(4'h5, 8'h5a);
    rd(4'h5, 8'h5a);
    wr(4'h6, 8'hff);
    rd(4'h6, 8'h9f);
    wr(4'h6, 8'h80);
    rd(4'h6, 8'h8c);
    @(posedge ref_clk) resetCauseSet <= 5'h01;
    @(posedge ref_clk) resetCauseSet <= 5'h00;
    rd(4'h6, 8'h8d);
    wr(4'h2, 8'hc0);
    wr(4'h1, 8'h1f);
    wr(4'h4, 8'h00);
    pin(3'b010);
    rd(4'h0, 8'h02);
    irq(3'b101);
    wr(4'h0, 8'h02);
    pin(3'b000);
    rd(4'h0, 8'h00);
    irq(3'b000);
    pin(3'b001);
    rd(4'h0, 8'h01);
    irq(3'b110);
    wr(4'h0, 8'h01);
    wr(4'h3, 8'h55);
    pin(3'b010);
    rd(4'h0, 8'h00);
    pin(3'b000);
    rd(4'h0, 8'h02);
    wr(4'h0, 8'h02);
    wr(4'h1, 8'h1b);
    pin(3'b100);
    rd(4'h0, 8'h04);
    irq(3'b000);
    wr(4'h0, 8'h04);
    wr(4'h1, 8'h1f);
    pin(3'b000);
    pin(3'b100);
    irq(3'b101);
    wr(4'h6, 8'h0d);
    idle(2);
    irq(3'b110);
    wr(4'h6, 8'h8d);
    wr(4'h0, 8'h04);
    pin(3'b000);
    wr(4'h1, 8'h01);
    @(posedge ref_clk) sleepCmd <= 1'b1;
    @(posedge ref_clk) sleepCmd <= 1'b0;
    pin(3'b100);
    chk({7'h00, cpuSleep}, 8'h01);
    pin(3'b101);
    chk({7'h00, cpuSleep}, 8'h00);
    chk(nWake, 8'h01);
    wr(4'h0, 8'h05);
    pin(3'b000);
    wr(4'h1, 8'h08);
    wr(4'h3, 8'h51);
    wr(4'h7, 8'hfe);
    tick(1);
    rd(4'h0, 8'h00);
    tick(1);
    rd(4'h7, 8'h00);
    rd(4'h8, 8'h00);
    rd(4'h0, 8'h08);
    irq(3'b101);
    wr(4'h0, 8'h08);
    wr(4'h2, 8'hc1);
    wr(4'h7, 8'hff);
    tick(1);
    rd(4'h8, 8'h01);
    rd(4'h0, 8'h00);
    wr(4'h7, 8'hff);
    wr(4'h8, 8'hff);
    tick(1);
    rd(4'h8, 8'h00);
    rd(4'h0, 8'h08);
    wr(4'h0, 8'h08);
    wr(4'h1, 8'h10);
    @(posedge ref_clk) portBHigh <= 4'h4;
    idle(6);
    rd(4'h0, 8'h10);
    irq(3'b110);
    wr(4'h0, 8'h10);
    @(posedge ref_clk) portBHigh <= 4'h0;
    idle(6);
    rd(4'h0, 8'h10);
    wr(4'h1, 8'h00);
    idle(2);
    irq(3'b000);
    @(posedge ref_clk) canFlag <= 8'h01;
    idle(4);
    irq(3'b001);
    @(posedge ref_clk) canFlag <= 8'h02;
    idle(4);
    irq(3'b010);
    tally_and_finish();
  end
endmodule // test_interrupt_source_priority
